// ===== logic/vls_line_slicer_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// [R01] hamming bit zero checks two bytes after framing
// [R02] strict bit refuses framing codes with one error
// [R03] search stop bit halts amplitude searching
// [R04] one type register per line, field nibbles
// [R05] code 0011 hunts wide-screen pattern 1E3C1Fh
// [R06] caption codes 0101, 0001 use pattern 001
// [R07] time code types use programmable framing code
// [R08] japanese switch and text use programmable code
// [R09] test line passes samples, no framing search
// [R10] code 1111 default, active video passed
// [R11] other codes: teletext, service data, raw, reserved
// [R12] field and line number pick the nibble
// [R13] programmable framing register resets to 40h
// [R14] status field reports current line data type
module vls_line_slicer_ctrl (
  clk_sys,
  rst,
  ce,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  line_start,
  line_end,
  line_num,
  field_id,
  bit_valid,
  bit_data,
  cur_type,
  slice_active,
  video_pass,
  amp_search_en,
  frame_found,
  frame_one_err,
  ham_done,
  ham_err
);
  input  wire logic        clk_sys;        // line-locked clock
  input  wire logic        rst;            // async reset, active high
  input  wire logic        ce;             // freezes all state when low
  input  wire logic [7:0]  reg_addr;       // register subaddress
  input  wire logic [7:0]  reg_wdata;      // write data
  input  wire logic        reg_wr;         // write strobe
  input  wire logic        reg_rd;         // read strobe
  output logic      [7:0]  reg_rdata;      // read data, one cycle after strobe
  input  wire logic        line_start;     // pulse at start of each line
  input  wire logic        line_end;       // pulse at end of each line
  input  wire logic [8:0]  line_num;       // line number of the new line
  input  wire logic        field_id;       // 0 field 1, 1 field 2
  input  wire logic        bit_valid;      // one sliced bit present
  input  wire logic        bit_data;       // sliced bit value
  output logic      [3:0]  cur_type;       // data type of current line
  output logic             slice_active;   // framing search or data collect
  output logic             video_pass;     // pass component samples
  output logic             amp_search_en;  // amplitude searching running
  output logic             frame_found;    // pulse: framing code accepted
  output logic             frame_one_err;  // accepted code had one error
  output logic             ham_done;       // pulse: two bytes checked
  output logic             ham_err;        // hamming failure on last check

  // line state machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HUNT = 2'b01,
    ST_DATA = 2'b10,
    ST_DONE = 2'b11
  } vls_state_t;

  vls_pkg::vls_ctrl_t      ctrl_q;          // slicer control fields
  logic [7:0]              line_q [vls_pkg::NUM_LINES];  // per-line types
  logic [7:0]              fc_q;            // programmable framing code
  logic [3:0]              type_q;          // latched type of this line
  logic [8:0]              lnum_q;          // latched line number
  logic                    fld_q;           // latched field
  logic [3:0]              sel_type;        // type picked for new line
  logic [4:0]              line_idx;        // table index of new line
  logic                    in_table;        // new line within 2..24
  vls_pkg::vls_type_cfg_t  cfg;             // decode of latched type
  vls_state_t              state_q;         // line state
  logic [23:0]             sr_q;            // received bit history
  logic [23:0]             sr_d;            // history with new bit
  logic [4:0]              seen_q;          // bits seen, saturating
  logic [4:0]              cnt_q;           // data bits collected
  logic [23:0]             len_mask;        // mask of framing length
  logic [4:0]              errs;            // framing mismatches
  logic                    match;           // framing accepted now
  logic                    ham_want;        // check requested this line
  logic [7:0]              rdata_d;         // read mux

  // decode of the line's data type
  vls_type_decode u_decode (
    .dtype   (type_q),
    .prog_fc (fc_q),
    .cfg     (cfg)
  );

  // slicer control register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl_q <= '0;
    else if (ce && reg_wr && reg_addr == vls_pkg::ADDR_CTRL)
    begin
      ctrl_q.ham_disable <= reg_wdata[vls_pkg::CTRL_HAM_BIT];   // [R01]
      ctrl_q.fc_strict   <= reg_wdata[vls_pkg::CTRL_FCE_BIT];   // [R02]
      ctrl_q.amp_stop    <= reg_wdata[vls_pkg::CTRL_HUNT_BIT];  // [R03]
    end
  end

  // one type register per line at consecutive subaddresses
  for (genvar g = 0; g < vls_pkg::NUM_LINES; g++)
  begin : g_line
    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
        line_q[g] <= vls_pkg::LINE_RST;  // [R10]
      else if (ce && reg_wr && reg_addr == vls_pkg::ADDR_LINE0 + 8'(g))
        line_q[g] <= reg_wdata;  // [R04]
    end
  end

  // programmable framing code register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      fc_q <= vls_pkg::FC_RST;  // [R13]
    else if (ce && reg_wr && reg_addr == vls_pkg::ADDR_FC)
      fc_q <= reg_wdata;
  end

  // nibble pick from field and line number
  always_comb
  begin
    in_table = (line_num >= vls_pkg::LINE_FIRST) && (line_num <= vls_pkg::LINE_LAST);
    line_idx = 5'(line_num - vls_pkg::LINE_FIRST);
    sel_type = vls_pkg::DT_VIDEO;
    if (in_table)
      sel_type = field_id ? line_q[line_idx][3:0] : line_q[line_idx][7:4];  // [R12] [R04]
  end

  // latch type, line and field at line start
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      type_q <= vls_pkg::DT_VIDEO;
      lnum_q <= '0;
      fld_q  <= 1'b0;
    end
    else if (ce && line_start)
    begin
      type_q <= sel_type;  // [R12]
      lnum_q <= line_num;
      fld_q  <= field_id;
    end
  end

  // framing comparison over the selected length
  always_comb
  begin
    sr_d     = {sr_q[22:0], bit_data};
    len_mask = ~(24'hFFFFFF << cfg.length);
    errs     = vls_pkg::vls_popcount((sr_d ^ cfg.pattern) & len_mask);
    match    = (5'(seen_q + 5'h01) >= cfg.length) &&
               ((errs == vls_pkg::ERR_NONE) ||
                (errs == vls_pkg::ERR_ONE && !ctrl_q.fc_strict));  // [R02]
    ham_want = cfg.hamming && !ctrl_q.ham_disable;  // [R01]
  end

  // per-line sequence: hunt framing, then collect checked bytes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_q <= ST_IDLE;
    else if (ce)
    begin
      if (line_start)
        state_q <= ST_HUNT;  // type becomes valid next cycle
      else
      begin
        case (state_q)
          ST_IDLE:
            state_q <= ST_IDLE;
          ST_HUNT:
          begin
            if (!cfg.search)
              state_q <= ST_DONE;  // [R09] [R10]
            else if (line_end)
              state_q <= ST_IDLE;
            else if (bit_valid && match)
              state_q <= ham_want ? ST_DATA : ST_DONE;  // [R01]
          end
          ST_DATA:
          begin
            if (line_end)
              state_q <= ST_IDLE;
            else if (bit_valid && cnt_q == vls_pkg::HAM_BITS - 5'h01)
              state_q <= ST_DONE;
          end
          ST_DONE:
            state_q <= line_end ? ST_IDLE : ST_DONE;
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // bit history and counters
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sr_q   <= '0;
      seen_q <= '0;
      cnt_q  <= '0;
    end
    else if (ce)
    begin
      if (line_start)
      begin
        sr_q   <= '0;
        seen_q <= '0;
        cnt_q  <= '0;
      end
      else if (bit_valid && (state_q == ST_HUNT || state_q == ST_DATA))
      begin
        sr_q <= sr_d;
        if (seen_q != vls_pkg::SEEN_MAX)
          seen_q <= 5'(seen_q + 5'h01);
        if (state_q == ST_DATA)
          cnt_q <= 5'(cnt_q + 5'h01);
      end
    end
  end

  // framing result flags
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      frame_found   <= 1'b0;
      frame_one_err <= 1'b0;
    end
    else if (ce)
    begin
      frame_found <= (state_q == ST_HUNT) && cfg.search && bit_valid && match &&
                     !line_start && !line_end;
      if (line_start)
        frame_one_err <= 1'b0;
      else if (state_q == ST_HUNT && cfg.search && bit_valid && match && !line_end)
        frame_one_err <= (errs == vls_pkg::ERR_ONE);  // [R02]
    end
  end

  // hamming check of the two bytes after framing
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ham_done <= 1'b0;
      ham_err  <= 1'b0;
    end
    else if (ce)
    begin
      ham_done <= 1'b0;
      if (state_q == ST_DATA && bit_valid && !line_start && !line_end &&
          cnt_q == vls_pkg::HAM_BITS - 5'h01)
      begin
        ham_done <= 1'b1;  // [R01]
        ham_err  <= !(vls_pkg::vls_ham_ok(sr_d[15:8]) && vls_pkg::vls_ham_ok(sr_d[7:0]));
      end
    end
  end

  // level outputs toward the slicer datapath
  always_comb
  begin
    cur_type      = type_q;  // [R14]
    slice_active  = (state_q == ST_HUNT || state_q == ST_DATA) && cfg.search;
    video_pass    = (state_q != ST_IDLE) && cfg.pass_video;  // [R09] [R10]
    amp_search_en = !ctrl_q.amp_stop;  // [R03]
  end

  // register read mux; unmapped subaddresses read zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_addr == vls_pkg::ADDR_CTRL)
      rdata_d = 8'({ctrl_q, 4'h0});
    else if (reg_addr >= vls_pkg::ADDR_LINE0 && reg_addr <= vls_pkg::ADDR_LINEN)
      rdata_d = line_q[5'(reg_addr - vls_pkg::ADDR_LINE0)];
    else if (reg_addr == vls_pkg::ADDR_FC)
      rdata_d = fc_q;
    else if (reg_addr == vls_pkg::ADDR_STAT1)
      rdata_d = {2'h0, fld_q, lnum_q[8:4]};
    else if (reg_addr == vls_pkg::ADDR_STAT2)
      rdata_d = {lnum_q[3:0], type_q};  // [R14]
  end

  // read data held in a register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (ce && reg_rd)
      reg_rdata <= rdata_d;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // stopped searching never runs
  property p_amp_stop;
    ce && reg_wr && reg_addr == vls_pkg::ADDR_CTRL && reg_wdata[vls_pkg::CTRL_HUNT_BIT]
      |=> !amp_search_en;
  endproperty
  a_amp_stop: assert property (p_amp_stop) else $error("search not stopped"); // [R03]

  // lines after the table, above line 24, are active video
  property p_default_video;
    ce && line_start && line_num > vls_pkg::LINE_LAST |=> cur_type == vls_pkg::DT_VIDEO;
  endproperty
  a_default_video: assert property (p_default_video) else $error("bad default type"); // [R10]

  // field nibble chosen from table
  property p_nibble;
    ce && line_start && in_table
      |=> cur_type == (fld_q ? $past(line_q[line_idx][3:0]) : $past(line_q[line_idx][7:4]));
  endproperty
  a_nibble: assert property (p_nibble) else $error("wrong nibble picked"); // [R12]

  // a one-error frame only when tolerance allowed
  property p_strict;
    frame_found && frame_one_err |-> !$past(ctrl_q.fc_strict);
  endproperty
  a_strict: assert property (p_strict) else $error("error frame taken in strict mode"); // [R02]

  // no hamming result when checking is disabled
  property p_ham_off;
    ham_done |-> !$past(ctrl_q.ham_disable) && $past(state_q) == ST_DATA;
  endproperty
  a_ham_off: assert property (p_ham_off) else $error("hamming ran while disabled"); // [R01]

  // test line passes video without searching
  property p_test_line;
    ce && line_start && sel_type == vls_pkg::DT_TEST
      |=> ##1 (!ce || (video_pass && !slice_active && !frame_found));
  endproperty
  a_test_line: assert property (p_test_line) else $error("test line not passed"); // [R09]

  // framing register write lands
  property p_fc_write;
    ce && reg_wr && reg_addr == vls_pkg::ADDR_FC |=> fc_q == $past(reg_wdata);
  endproperty
  a_fc_write: assert property (p_fc_write) else $error("framing code not written"); // [R13]

  // wide-screen type hunts its fixed pattern
  property p_wss;
    type_q == vls_pkg::DT_WSS |-> cfg.pattern == 24'h1E3C1F && cfg.length == 5'h18;
  endproperty
  a_wss: assert property (p_wss) else $error("wrong wide-screen pattern"); // [R05]

  // status read returns the current type
  property p_status;
    ce && reg_rd && reg_addr == vls_pkg::ADDR_STAT2 |=> reg_rdata[3:0] == $past(type_q);
  endproperty
  a_status: assert property (p_status) else $error("status type mismatch"); // [R14]

endmodule

// ===== logic/vls_pkg.sv
package vls_pkg;

  // per-line table spans video lines 2 to 24
  localparam int        NUM_LINES  = 23;
  localparam logic[8:0] LINE_FIRST = 9'h002;
  localparam logic[8:0] LINE_LAST  = 9'h018;

  // register subaddresses
  localparam logic[7:0] ADDR_CTRL  = 8'h40;
  localparam logic[7:0] ADDR_LINE0 = 8'h41;
  localparam logic[7:0] ADDR_LINEN = 8'h57;
  localparam logic[7:0] ADDR_FC    = 8'h58;
  localparam logic[7:0] ADDR_STAT1 = 8'h61;
  localparam logic[7:0] ADDR_STAT2 = 8'h62;

  // control register bit positions and reset values
  localparam int        CTRL_HAM_BIT  = 6;
  localparam int        CTRL_FCE_BIT  = 5;
  localparam int        CTRL_HUNT_BIT = 4;
  localparam logic[7:0] CTRL_RST      = 8'h00;
  localparam logic[7:0] LINE_RST      = 8'hFF;
  localparam logic[7:0] FC_RST        = 8'h40;

  // framing search constants
  localparam logic[4:0] SEEN_MAX  = 5'h18;
  localparam logic[4:0] HAM_BITS  = 5'h10;
  localparam logic[4:0] ERR_NONE  = 5'h00;
  localparam logic[4:0] ERR_ONE   = 5'h01;

  // fixed framing patterns, last received bit in bit 0, and their lengths
  localparam logic[23:0] PAT_TTX  = 24'h000027;
  localparam logic[23:0] PAT_CC   = 24'h000001;
  localparam logic[23:0] PAT_PSD  = 24'h009951;
  localparam logic[23:0] PAT_WSS  = 24'h1E3C1F;
  localparam logic[4:0]  LEN_TTX  = 5'h08;
  localparam logic[4:0]  LEN_CC   = 5'h03;
  localparam logic[4:0]  LEN_PSD  = 5'h10;
  localparam logic[4:0]  LEN_WSS  = 5'h18;
  localparam logic[4:0]  LEN_PROG = 5'h08;

  // data type codes, same for both fields
  typedef enum logic [3:0] {
    DT_TTX625  = 4'b0000,
    DT_CAPTION_625_TYPE   = 4'b0001,
    DT_PSD     = 4'b0010,
    DT_WSS     = 4'b0011,
    DT_TTX525  = 4'b0100,
    DT_CAPTION_525_TYPE   = 4'b0101,
    DT_TEST    = 4'b0110,
    DT_RAW     = 4'b0111,
    DT_GTEXT   = 4'b1000,
    DT_TC625   = 4'b1001,
    DT_TC525   = 4'b1010,
    DT_RSVD    = 4'b1011,
    DT_USBT    = 4'b1100,
    DT_JTEXT   = 4'b1101,
    DT_JSWITCH = 4'b1110,
    DT_VIDEO   = 4'b1111
  } vls_dtype_t;

  // what one data type asks of the slicer
  typedef struct packed {
    logic [23:0] pattern;     // framing bits, last received in bit 0
    logic [4:0]  length;      // framing length in bits
    logic        search;      // framing search wanted
    logic        hamming;     // type calls for hamming check
    logic        pass_video;  // pass component samples
  } vls_type_cfg_t;

  // slicer control register fields
  typedef struct packed {
    logic ham_disable;
    logic fc_strict;
    logic amp_stop;
  } vls_ctrl_t;

  // count of ones in a 24-bit word
  function automatic logic [4:0] vls_popcount(input logic [23:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 24; i++)
      n = n + {4'h0, v[i]};
    return n;
  endfunction

  // hamming 8/4 byte: all four parity groups must be odd
  function automatic logic vls_ham_ok(input logic [7:0] b);
    logic a;
    logic c;
    logic d;
    logic e;
    a = b[0] ^ b[1] ^ b[5] ^ b[7];
    c = b[1] ^ b[2] ^ b[3] ^ b[7];
    d = b[1] ^ b[3] ^ b[4] ^ b[5];
    e = ^b;
    return a & c & d & e;
  endfunction

endpackage

// ===== logic/vls_type_decode.sv
`timescale 1ns/1ns
// maps a data type code onto its framing and checking needs
module vls_type_decode (
  input  wire logic [3:0]            dtype,
  input  wire logic [7:0]            prog_fc,
  output vls_pkg::vls_type_cfg_t     cfg
);

  // one decode per code; programmable types use the framing register
  always_comb
  begin
    cfg = '0;
    case (dtype)
      vls_pkg::DT_TTX625, vls_pkg::DT_TTX525:
      begin
        cfg.pattern = vls_pkg::PAT_TTX;  // [R11]
        cfg.length  = vls_pkg::LEN_TTX;
        cfg.search  = 1'b1;
        cfg.hamming = 1'b1;
      end
      vls_pkg::DT_CAPTION_625_TYPE, vls_pkg::DT_CAPTION_525_TYPE:
      begin
        cfg.pattern = vls_pkg::PAT_CC;  // [R06]
        cfg.length  = vls_pkg::LEN_CC;
        cfg.search  = 1'b1;
      end
      vls_pkg::DT_PSD:
      begin
        cfg.pattern = vls_pkg::PAT_PSD;  // [R11]
        cfg.length  = vls_pkg::LEN_PSD;
        cfg.search  = 1'b1;
      end
      vls_pkg::DT_WSS:
      begin
        cfg.pattern = vls_pkg::PAT_WSS;  // [R05]
        cfg.length  = vls_pkg::LEN_WSS;
        cfg.search  = 1'b1;
      end
      vls_pkg::DT_GTEXT, vls_pkg::DT_TC625, vls_pkg::DT_TC525,
      vls_pkg::DT_JTEXT, vls_pkg::DT_JSWITCH:
      begin
        cfg.pattern = {16'h0000, prog_fc};  // [R07] [R08] [R13]
        cfg.length  = vls_pkg::LEN_PROG;
        cfg.search  = 1'b1;
        cfg.hamming = (dtype == vls_pkg::DT_GTEXT);
      end
      vls_pkg::DT_TEST, vls_pkg::DT_VIDEO:
        cfg.pass_video = 1'b1;  // [R09] [R10]
      default:
        cfg = '0;  // raw, reserved, broadcast text: no framing
    endcase
  end

endmodule

// ===== test/vls_line_slicer_ctrl_test.sv
`timescale 1ns/1ns
// self-checking bench: register model and per-line expectations
module vls_line_slicer_ctrl_test;
  localparam int PLEN [16] = '{8, 3, 16, 24, 8, 3, 0, 0, 8, 8, 8, 0, 0, 8, 8, 0};
  logic        clk_sys;        // 125 mhz clock
  logic        rst;            // async reset
  logic        ce;             // clock enable
  logic        reg_wr;         // write strobe
  logic        reg_rd;         // read strobe
  logic [7:0]  reg_addr;       // subaddress
  logic [7:0]  reg_wdata;      // write data
  logic [7:0]  reg_rdata;      // read data
  logic        line_start;     // partner line pulse
  logic        line_end;       // partner end pulse
  logic [8:0]  line_num;       // partner line number
  logic        field_id;       // partner field
  logic        bit_valid;      // partner bit strobe
  logic        bit_data;       // partner bit value
  logic [3:0]  cur_type;       // current data type
  logic        slice_active;   // search running
  logic        video_pass;     // samples passed
  logic        amp_search_en;  // amplitude search on
  logic        frame_found;    // framing accepted
  logic        frame_one_err;  // accepted with one error
  logic        ham_done;       // bytes checked
  logic        ham_err;        // byte check failed
  int          errors;         // mismatches
  int          compares;       // comparisons made
  int          seed;           // random seed
  int          cyc;            // cycle count for timeout
  int          nf;             // frame_found pulses this line
  int          nh;             // ham_done pulses this line
  logic [7:0]  lmem [2:24];    // model of line registers

  vls_line_slicer_ctrl vls_line_slicer_ctrl_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_start(line_start), .line_end(line_end),
    .line_num(line_num), .field_id(field_id), .bit_valid(bit_valid), .bit_data(bit_data),
    .cur_type(cur_type), .slice_active(slice_active), .video_pass(video_pass),
    .amp_search_en(amp_search_en), .frame_found(frame_found),
    .frame_one_err(frame_one_err), .ham_done(ham_done), .ham_err(ham_err));
  vls_video_src vls_video_src_i (.clk_sys(clk_sys), .line_start(line_start),
    .line_end(line_end), .line_num(line_num), .field_id(field_id),
    .bit_valid(bit_valid), .bit_data(bit_data));

  // free-running clock
  initial
  begin
    clk_sys = 1'b0;
  end
  always #4 clk_sys = ~clk_sys;

  // count result pulses and cut a hang short
  always @(posedge clk_sys)
  begin
    nf  = nf + int'(frame_found === 1'b1);
    nh  = nh + int'(ham_done === 1'b1);
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      end_sim();
    end
  end

  // compare one value and report a mismatch
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // register write, entered and left at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  // register read, data taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    q = reg_rdata;
  endtask

  // framing bits of each code, last received bit in bit 0
  function automatic logic [23:0] pattern(input int c, input logic [7:0] fc);
    case (c)
      0, 4:    return 24'h000027;
      1, 5:    return 24'h000001;
      2:       return 24'h009951;
      3:       return 24'h1E3C1F;
      default: return {16'h0000, fc};
    endcase
  endfunction

  // byte protection: four odd parity groups
  function automatic logic hok(input logic [7:0] b);
    return (b[0] ^ b[1] ^ b[5] ^ b[7]) & (b[1] ^ b[2] ^ b[3] ^ b[7])
           & (b[1] ^ b[3] ^ b[4] ^ b[5]) & (^b);
  endfunction

  // counts, verdict and end of run
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence
  initial
  begin
    logic [7:0]  q;
    logic [7:0]  cv;
    logic [7:0]  fcv;
    logic [7:0]  lv;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [23:0] p;
    logic [8:0]  ln;
    logic        f;
    logic        mt;
    logic        hm;
    int          c;
    int          e;
    int          ps;
    int          len;
    errors    = 0;
    compares  = 0;
    cyc       = 0;
    nf        = 0;
    nh        = 0;
    seed      = 32'h7013;
    rst       = 1'b1;
    ce        = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    check("cur_type", 8'(cur_type), 8'h0F);
    check("amp_en", 8'(amp_search_en), 8'h01);
    rd(vls_pkg::ADDR_CTRL, q);
    check("ctrl", q, 8'h00);
    rd(vls_pkg::ADDR_FC, q);
    check("fc", q, 8'h40);
    for (int i = 2; i <= 24; i++)
    begin
      lmem[i] = 8'hFF;
      rd(8'(vls_pkg::ADDR_LINE0 + i - 2), q);
      check("line reset", q, lmem[i]);
    end
    wr(8'h30, 8'h5A);
    rd(8'h30, q);
    check("unmapped", q, 8'h00);
    $display("test reset values done");
    for (int k = 0; k < 32; k++)
    begin
      c   = k % 16;
      ln  = 9'(2 + ($unsigned($random(seed)) % 23));
      f   = 1'($random(seed));
      cv  = 8'($random(seed));
      fcv = (c == 13) ? 8'hA7 : 8'($random(seed));
      lv  = 8'($random(seed));
      if (f)
        lv[3:0] = 4'(c);
      else
        lv[7:4] = 4'(c);
      e = (k < 16) ? 0 : $unsigned($random(seed)) % 3;
      if (k < 16)
        cv[6] = 1'b0;
      lmem[ln] = lv;
      wr(8'(vls_pkg::ADDR_LINE0 + ln - 2), lv);
      wr(vls_pkg::ADDR_FC, fcv);
      wr(vls_pkg::ADDR_CTRL, cv);
      rd(vls_pkg::ADDR_CTRL, q);
      check("ctrl rb", q, cv & 8'h70);
      check("amp_en", 8'(amp_search_en), 8'(!cv[4]));
      nf = 0;
      nh = 0;
      vls_video_src_i.open_line(ln, f);
      len = PLEN[c];
      mt  = (len != 0) && (e == 0 || (e == 1 && !cv[5]));
      hm  = mt && (c == 0 || c == 4 || c == 8) && !cv[6];
      check("cur_type", 8'(cur_type), 8'(c));
      check("vpass", 8'(video_pass), 8'(c == 6 || c == 15));
      check("slicing", 8'(slice_active), 8'(len != 0));
      @(negedge clk_sys);
      if (len != 0)
      begin
        p  = pattern(c, fcv);
        ps = $unsigned($random(seed)) % len;
        if (e > 0)
          p[ps] = ~p[ps];
        if (e > 1)
          p[(ps + 1) % len] = ~p[(ps + 1) % len];
        vls_video_src_i.send_bits(p, len);
      end
      b1 = 8'($random(seed));
      b2 = 8'($random(seed));
      if (c != 4)
        repeat (300) if (!hok(b1) || !hok(b2)) {b1, b2} = 16'($random(seed));
      // one idle edge between framing and data keeps the strobe clean
      if (mt)
      begin
        @(negedge clk_sys);
        vls_video_src_i.send_bits({8'h00, b1, b2}, 16);
      end
      repeat (2) @(negedge clk_sys);
      check("found", 8'(nf), 8'(mt));
      check("one_err", 8'(frame_one_err), 8'(mt && e == 1));
      check("ham_done", 8'(nh), 8'(hm));
      if (hm)
        check("ham_err", 8'(ham_err), 8'(!(hok(b1) && hok(b2))));
      rd(vls_pkg::ADDR_STAT1, q);
      check("stat1", q, {2'b00, f, ln[8:4]});
      rd(vls_pkg::ADDR_STAT2, q);
      check("stat2", q, {ln[3:0], 4'(c)});
      vls_video_src_i.close_line();
    end
    $display("test line types done");
    for (int i = 2; i <= 24; i++)
    begin
      rd(8'(vls_pkg::ADDR_LINE0 + i - 2), q);
      check("line rb", q, lmem[i]);
    end
    // a write while the clock enable is low must not land
    ce = 1'b0;
    wr(vls_pkg::ADDR_FC, ~fcv);
    ce = 1'b1;
    rd(vls_pkg::ADDR_FC, q);
    check("ce hold", q, fcv);
    vls_video_src_i.open_line(9'h019, 1'b0);
    check("out of range", 8'(cur_type), 8'h0F);
    vls_video_src_i.close_line();
    $display("test readback done");
    end_sim();
  end
endmodule

// ===== test/vls_video_src.sv
`timescale 1ns/1ns
// video front end model: line timing pulses and sliced bits, changed at falling edge
module vls_video_src (
  clk_sys,
  line_start,
  line_end,
  line_num,
  field_id,
  bit_valid,
  bit_data
);
  input  wire logic        clk_sys;     // line-locked clock
  output logic             line_start;  // one-cycle line start pulse
  output logic             line_end;    // one-cycle line end pulse
  output logic      [8:0]  line_num;    // number of the line being opened
  output logic             field_id;    // 0 field 1, 1 field 2
  output logic             bit_valid;   // one sliced bit present
  output logic             bit_data;    // sliced bit value

  // idle front end at time zero
  initial
  begin
    line_start = 1'b0;
    line_end   = 1'b0;
    line_num   = 9'h000;
    field_id   = 1'b0;
    bit_valid  = 1'b0;
    bit_data   = 1'b0;
  end

  // open a line; number and field qualify the pulse only
  task automatic open_line(input logic [8:0] n, input logic f);
    @(negedge clk_sys);
    line_start = 1'b1;
    line_num   = n;
    field_id   = f;
    @(negedge clk_sys);
    line_start = 1'b0;
    line_num   = ~n;  // released, so no stale value
    field_id   = ~f;
  endtask

  // shift out len bits, first bit is bit len-1, one bit a cycle
  task automatic send_bits(input logic [23:0] v, input int len);
    for (int i = len - 1; i >= 0; i--)
    begin
      bit_valid = 1'b1;
      bit_data  = v[i];
      @(negedge clk_sys);
    end
    bit_valid = 1'b0;
    bit_data  = ~bit_data;  // idle data line keeps moving
  endtask

  // end pulse closes the line
  task automatic close_line();
    line_end = 1'b1;
    @(negedge clk_sys);
    line_end = 1'b0;
    @(negedge clk_sys);
  endtask
endmodule
